// [src/dmh_pkg.sv]
// Shared constants and types for the display module host controller
package dmh_pkg;

   // ---------------------------------------------------------------
   // Register map (APB, byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RDATA  = 8'h0C;

   // CTRL fields
   localparam int CTRL_STYLE_LSB = 0;
   localparam int CTRL_WIDE_BIT  = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

   // CMD fields: data[7:0], select bit 8, read bit 9
   localparam int CMD_SEL_BIT  = 8;
   localparam int CMD_READ_BIT = 9;

   // STATUS fields
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_READY_BIT = 1;
   localparam int ST_DONE_BIT  = 2;

   // Serial start byte: five ones, direction, select, zero
   localparam logic [4:0] START_ONES = 5'h1F;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS       = 100;
   localparam int PHASE_NS     = 300;
   localparam int PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_US       = 1;
   localparam int GAP_CYC      = (GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PWRUP_MS     = 100;
   localparam int PWRUP_CYC    = PWRUP_MS * 1000000 / CLK_NS;
   localparam int CNT_W        = 20;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DMH_STYLE_ENABLE,
      DMH_STYLE_STROBES,
      DMH_STYLE_SERIAL,
      DMH_STYLE_RSVD
   } dmh_style_t;

   typedef struct packed {
      logic [7:0] bus_out;
      logic [7:0] bus_oe_n;
      logic       cmd_or_data_select;
      logic       enable;
      logic       rw_level;
      logic       wr_n;
      logic       rd_n;
      logic       frame_select_n;
      logic       sck;
      logic       sio_out;
      logic       sio_oe_n;
   } dmh_pins_t;

   typedef struct packed {
      logic [7:0] data;
      logic       sel;
      logic       rd;
   } dmh_req_t;

endpackage

// [src/dmh_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dmh_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dmh_sync_st_t;

   dmh_sync_st_t st;
   dmh_sync_st_t next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule // dmh_sync

// [src/dmh_apb.sv]
// APB slave holding the controller's own registers
`timescale 1ns/10ps
module dmh_apb (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      ctrl,
   output logic             req_valid,
   output dmh_pkg::dmh_req_t req,
   input  wire logic        busy,
   input  wire logic        pwr_ready,
   input  wire logic        done,
   input  wire logic [7:0]  rdata
);
   typedef struct packed {
      logic [31:0]        ctrl;
      logic               req_valid;
      dmh_pkg::dmh_req_t  req;
      logic               done;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
   } dmh_apb_st_t;

   dmh_apb_st_t st;
   dmh_apb_st_t next_st;
   logic        acc;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   always_comb begin
      next_st           = st;
      acc               = psel && penable && !st.pready;
      next_st.pready    = acc;
      next_st.pslverr   = 1'b0;
      next_st.req_valid = 1'b0;
      // Set wins over a status-read clear on the done flag; an accepted command write clears it even then
      if (done) begin
         next_st.done = 1'b1;
      end
      if (acc) begin
         next_st.prdata = 32'h0000_0000;
         case (paddr)
            dmh_pkg::ADDR_CTRL: begin
               if (pwrite) begin
                  next_st.ctrl = {29'h0000_0000, pwdata[2:0]};
               end
               next_st.prdata = st.ctrl;
            end
            dmh_pkg::ADDR_CMD: begin
               // Writes while busy are refused
               if (pwrite && !busy && pwr_ready) begin
                  next_st.req_valid = 1'b1;
                  next_st.req.data  = pwdata[7:0];
                  next_st.req.sel   = pwdata[dmh_pkg::CMD_SEL_BIT];
                  next_st.req.rd    = pwdata[dmh_pkg::CMD_READ_BIT];
                  next_st.done      = 1'b0;
               end else if (pwrite) begin
                  next_st.pslverr = 1'b1;
               end
            end
            dmh_pkg::ADDR_STATUS: begin
               next_st.prdata = {29'h0000_0000, st.done, pwr_ready, busy};
               if (!pwrite && !done) begin
                  next_st.done = 1'b0;
               end
            end
            dmh_pkg::ADDR_RDATA: begin
               next_st.prdata = {24'h00_0000, rdata};
            end
            default: begin
               next_st.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st      <= '0;
         st.ctrl <= dmh_pkg::CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata    = st.prdata;
   assign pready    = st.pready;
   assign pslverr   = st.pslverr;
   assign ctrl      = st.ctrl;
   assign req_valid = st.req_valid;
   assign req       = st.req;
endmodule // dmh_apb

// [src/dmh_host.sv]
// Host controller driving the character display module pins
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module dmh_host #(
   parameter int PWRUP_CYCLES = dmh_pkg::PWRUP_CYC
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [7:0]   parallel_bus_in,
   input  wire logic         sio_in,
   output dmh_pkg::dmh_pins_t pins
);
   typedef enum {
      S_PWRUP, S_IDLE, S_SETUP, S_HI, S_LO, S_GAP, S_SBIT_LO, S_SBIT_HI,
      S_CLOSE
   } dmh_state_t;

   typedef struct packed {
      dmh_state_t         state;
      logic [dmh_pkg::CNT_W-1:0] cnt;
      logic               nib_hi;
      logic               second;
      logic [2:0]         bitn;
      logic [7:0]         shift;
      logic [7:0]         rdata;
      logic               busy;
      logic               pwr_ready;
      logic               done;
      logic               rd;
      logic [1:0]         style;
      logic               wide;
      dmh_pkg::dmh_pins_t pins;
   } dmh_host_st_t;

   dmh_host_st_t      st;
   dmh_host_st_t      next_st;
   logic [31:0]       ctrl;
   logic              req_valid;
   dmh_pkg::dmh_req_t req;
   logic [8:0]        sync_q;
   logic              phase_end;

   // All checks below share this clock and reset
   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ---------------------------------------------------------------
   // Register block and input synchronisers
   // ---------------------------------------------------------------
   dmh_apb u_apb (
      .clk       (clk),
      .resetn    (resetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .ctrl      (ctrl),
      .req_valid (req_valid),
      .req       (req),
      .busy      (st.busy),
      .pwr_ready (st.pwr_ready),
      .done      (st.done),
      .rdata     (st.rdata)
   );

   // Bus and serial line come from the module's clock-free domain
   dmh_sync #(.W(9)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({sio_in, parallel_bus_in}),
      .q      (sync_q)
   );

   function automatic logic [7:0] start_byte(input logic rd,
                                             input logic sel);
      start_byte = {dmh_pkg::START_ONES, rd, sel, 1'b0};
   endfunction

   // Parallel lane image; nibble mode puts halves on upper lanes
   function automatic logic [7:0] lane_val(input logic wide,
                                           input logic hi,
                                           input logic [7:0] d);
      if (wide) begin
         lane_val = d;
      end else if (hi) begin
         lane_val = {d[7:4], 4'h0};
      end else begin
         lane_val = {d[3:0], 4'h0};
      end
   endfunction

   assign phase_end = (st.cnt == dmh_pkg::CNT_W'(dmh_pkg::PHASE_CYC - 1));

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      next_st.cnt  = st.cnt + 1'b1;
      case (st.state)
         S_PWRUP: begin
            // Module holds itself in reset after power-up
            if (st.cnt == dmh_pkg::CNT_W'(PWRUP_CYCLES - 1)) begin
               next_st.pwr_ready = 1'b1;
               next_st.state     = S_IDLE;
            end
         end
         S_IDLE: begin
            next_st.cnt = '0;
            // Style latched per transfer, never from a command
            next_st.style = ctrl[1:0];
            next_st.wide  = ctrl[dmh_pkg::CTRL_WIDE_BIT];
            if (req_valid) begin
               next_st.busy   = 1'b1;
               next_st.rd     = req.rd;
               next_st.nib_hi = 1'b1;
               next_st.second = 1'b0;
               next_st.bitn   = 3'd7;
               next_st.pins.cmd_or_data_select = req.sel;
               next_st.pins.rw_level = req.rd;
               if (ctrl[1:0] == 2'(dmh_pkg::DMH_STYLE_SERIAL)) begin
                  next_st.shift = start_byte(req.rd, req.sel);
                  next_st.rdata = req.data;
                  next_st.pins.frame_select_n = 1'b0;
                  next_st.state = S_SBIT_LO;
               end else begin
                  next_st.shift = req.data;
                  next_st.state = S_SETUP;
               end
            end
         end
         S_SETUP: begin
            if (!st.rd) begin
               next_st.pins.bus_out  = lane_val(st.wide, st.nib_hi, st.shift);
               next_st.pins.bus_oe_n = 8'h00;
            end
            if (phase_end) begin
               next_st.cnt = '0;
               if (st.style == 2'(dmh_pkg::DMH_STYLE_ENABLE)) begin
                  next_st.pins.enable = 1'b1;
               end else if (st.rd) begin
                  next_st.pins.rd_n = 1'b0;
               end else begin
                  next_st.pins.wr_n = 1'b0;
               end
               next_st.state = S_HI;
            end
         end
         S_HI: begin
            if (phase_end) begin
               next_st.cnt = '0;
               if (st.rd) begin
                  // Sample before releasing; device drives while active
                  if (st.wide) begin
                     next_st.rdata = sync_q[7:0];
                  end else if (st.nib_hi) begin
                     next_st.rdata[7:4] = sync_q[7:4];
                  end else begin
                     next_st.rdata[3:0] = sync_q[7:4];
                  end
               end
               next_st.pins.enable = 1'b0;
               next_st.pins.wr_n   = 1'b1;
               next_st.pins.rd_n   = 1'b1;
               next_st.state       = S_LO;
            end
         end
         S_LO: begin
            if (phase_end) begin
               next_st.cnt           = '0;
               next_st.pins.bus_oe_n = 8'hFF;
               if (!st.wide && st.nib_hi) begin
                  next_st.nib_hi = 1'b0;
                  next_st.state  = S_SETUP;
               end else begin
                  next_st.done  = 1'b1;
                  next_st.busy  = 1'b0;
                  next_st.state = S_IDLE;
               end
            end
         end
         S_SBIT_LO: begin
            // Data changes while clock low; device samples on rise
            if (!(st.second && st.rd)) begin
               next_st.pins.sio_out  = st.shift[st.bitn];
               next_st.pins.sio_oe_n = 1'b0;
            end else begin
               next_st.pins.sio_oe_n = 1'b1;
            end
            if (phase_end) begin
               next_st.cnt      = '0;
               next_st.pins.sck = 1'b1;
               next_st.state    = S_SBIT_HI;
            end
         end
         S_SBIT_HI: begin
            if (phase_end) begin
               next_st.cnt = '0;
               if (st.second && st.rd) begin
                  // Device drives after falling edge; read late in phase
                  next_st.shift[st.bitn] = sync_q[8];
               end
               next_st.pins.sck = 1'b0;
               next_st.bitn     = st.bitn - 3'd1;
               if (st.bitn == 3'd0 && st.rd) begin
                  // Device takes the line after this fall; let go now
                  next_st.pins.sio_oe_n = 1'b1;
               end
               if (st.bitn == 3'd0) begin
                  next_st.state = st.second ? S_CLOSE : S_GAP;
               end else begin
                  next_st.state = S_SBIT_LO;
               end
            end
         end
         S_GAP: begin
            if (st.cnt == dmh_pkg::CNT_W'(dmh_pkg::GAP_CYC - 1)) begin
               next_st.cnt    = '0;
               next_st.second = 1'b1;
               next_st.shift  = st.rd ? 8'h00 : st.rdata;
               next_st.state  = S_SBIT_LO;
            end
         end
         S_CLOSE: begin
            next_st.pins.sio_oe_n = 1'b1;
            if (phase_end) begin
               next_st.pins.frame_select_n = 1'b1;
               if (st.rd) begin
                  next_st.rdata = st.shift;
               end
               next_st.done  = 1'b1;
               next_st.busy  = 1'b0;
               next_st.state = S_IDLE;
            end
         end
         default: begin
            next_st.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st                     <= '0;
         st.state               <= S_PWRUP;
         st.pins.bus_oe_n       <= 8'hFF;
         st.pins.wr_n           <= 1'b1;
         st.pins.rd_n           <= 1'b1;
         st.pins.frame_select_n <= 1'b1;
         st.pins.sio_oe_n       <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign pins = st.pins;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence frame_open_s;
      $fell(st.pins.frame_select_n);
   endsequence

   sequence gap_enter_s;
      $rose(st.state == S_GAP);
   endsequence

   no_early_xfer_a: assert property (
      !st.pwr_ready |-> st.pins.frame_select_n && !st.pins.enable
      && st.pins.wr_n && st.pins.rd_n)
      else $error("transfer before power-up delay");
   gap_idle_a: assert property (
      (st.state == S_GAP) |-> !st.pins.sck)
      else $error("shift clock active in byte gap");
   gap_len_a: assert property (
      gap_enter_s |-> (st.state == S_GAP) [*8])
      else $error("byte gap too short");
   start_byte_a: assert property (
      frame_open_s |-> st.shift[7:3] == dmh_pkg::START_ONES
      && st.shift[0] == 1'b0)
      else $error("bad start byte");
   start_dir_a: assert property (
      frame_open_s |-> st.shift[2] == st.rd)
      else $error("direction bit mismatch");
   start_sel_a: assert property (
      frame_open_s |-> st.shift[1] == st.pins.cmd_or_data_select)
      else $error("select bit mismatch");
   frame_close_a: assert property (
      $rose(st.pins.frame_select_n) |-> st.done)
      else $error("frame closed without commit");
   frame_held_a: assert property (
      (st.state == S_GAP) || (st.state == S_CLOSE) |-> !st.pins.frame_select_n)
      else $error("frame strobe rose inside a cycle");
   sck_frame_a: assert property (
      st.pins.sck |-> !st.pins.frame_select_n)
      else $error("shift clock outside a frame");
   gap_release_a: assert property (
      (st.state == S_GAP) && st.rd |-> st.pins.sio_oe_n)
      else $error("serial line still driven before read byte");
   wr_rise_a: assert property (
      $rose(st.pins.wr_n) |-> !st.pins.bus_oe_n[7])
      else $error("bus not driven at write strobe rise");
   en_fall_a: assert property (
      $fell(st.pins.enable) && !st.rd |-> !st.pins.bus_oe_n[7]
      && !st.pins.rw_level)
      else $error("enable fell without driven write");
   nibble_lanes_a: assert property (
      !st.wide && !st.pins.bus_oe_n[0] |-> st.pins.bus_out[3:0] == 4'h0)
      else $error("lower lanes used in nibble mode");
endmodule // dmh_host

// [tb/dmh_dev_model.sv]
// Behavioural display module answering the host controller's pins
`timescale 1ns/10ps
module dmh_dev_model (
   input  wire dmh_pkg::dmh_pins_t pins,
   input  wire logic [7:0]         bus,
   input  wire logic               sio,
   input  wire logic [1:0]         style,    // Jumpers, static
   input  wire logic               wide,
   input  wire logic [7:0]         rd_val,
   output logic      [7:0]         drv_bus,
   output logic                    drv_bus_en,
   output logic                    drv_sio,
   output logic                    drv_sio_en,
   output logic      [7:0]         got_byte,
   output logic                    got_sel,
   output int                      got_cnt
);
   logic [15:0] sh;
   logic [7:0]  st;
   logic [3:0]  hi;
   logic        half = 1'b0;
   int          nbit;
   int          rbit;

   initial begin
      drv_bus_en = 1'b0;
      drv_sio_en = 1'b0;
      got_cnt    = 0;
   end

   // -----------------------------------------------------------
   // Parallel styles
   // -----------------------------------------------------------
   // Never busy: every strobe is served at once
   // Acts on settled pin edges, as after its synchronisers
   // Ignored lanes carry junk so a host that reads them is caught
   task automatic step(input logic rd);
      if (rd) begin
         drv_bus    = wide ? rd_val : half ? {rd_val[3:0], ~rd_val[3:0]}
                                           : {rd_val[7:4], ~rd_val[7:4]};
         drv_bus_en = 1'b1;
      end else if (wide)
         got_byte = bus;
      else if (half)
         got_byte = {hi, bus[7:4]};
      else
         hi = bus[7:4];
      half = wide ? 1'b0 : ~half;
      if (!half) begin
         got_sel = pins.cmd_or_data_select;
         got_cnt++;
      end
   endtask

   always @(negedge pins.enable)
      if (style == 2'd0) begin
         if (!pins.rw_level) step(1'b0);
         drv_bus_en = 1'b0;
      end
   always @(posedge pins.enable)
      if (style == 2'd0 && pins.rw_level) step(1'b1);
   always @(posedge pins.wr_n)
      if (style == 2'd1) step(1'b0);
   always @(negedge pins.rd_n)
      if (style == 2'd1) step(1'b1);
   always @(posedge pins.rd_n)
      drv_bus_en = 1'b0;

   // -----------------------------------------------------------
   // Serial style
   // -----------------------------------------------------------
   always @(negedge pins.frame_select_n) begin
      nbit       = 0;
      rbit       = 0;
      st         = 8'h00;
      drv_sio_en = 1'b0;
   end
   always @(posedge pins.sck)
      if (style == 2'd2 && !pins.frame_select_n && (nbit < 8 || !st[2])) begin
         sh = {sh[14:0], sio};
         nbit++;
         if (nbit == 8) st = sh[7:0];
      end
   always @(negedge pins.sck)
      if (style == 2'd2 && nbit >= 8 && st[2]) begin
         drv_sio_en = rbit < 8;
         if (rbit < 8) drv_sio = rd_val[7 - rbit];
         rbit++;
      end
   always @(posedge pins.frame_select_n) begin
      drv_sio_en = 1'b0;
      if (style == 2'd2 && st[7:3] == 5'h1F && !st[0]) begin
         if (!st[2] && nbit == 16) got_byte = sh[7:0];
         if (st[2] ? rbit >= 8 : nbit == 16) begin
            got_sel = st[1];
            got_cnt++;
         end
      end
   end
endmodule // dmh_dev_model

// [tb/tb_top.sv]
// Self-checking bench for the display module host controller
`timescale 1ns/10ps
module tb_top;
   logic               clk;
   logic               resetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   dmh_pkg::dmh_pins_t pins;
   logic [7:0]         bus_lvl;
   logic               sio_lvl;
   logic [7:0]         dev_bus;
   logic               dev_bus_en;
   logic               dev_sio;
   logic               dev_sio_en;
   logic [1:0]         style;
   logic               wide;
   logic [7:0]         rd_val;
   logic [7:0]         got_byte;
   logic               got_sel;
   int                 got_cnt;
   int                 fails;
   int                 tests_run;
   logic [31:0]        r;
   logic               e;

   // Pull-ups win wherever nobody drives
   assign bus_lvl = dev_bus_en ? dev_bus : pins.bus_out | pins.bus_oe_n;
   assign sio_lvl = dev_sio_en ? dev_sio : pins.sio_out | pins.sio_oe_n;

   dmh_host #(.PWRUP_CYCLES(20)) u_dut (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .parallel_bus_in(bus_lvl),
      .sio_in(sio_lvl), .pins(pins));

   dmh_dev_model u_dev (
      .pins(pins), .bus(bus_lvl), .sio(sio_lvl), .style(style),
      .wide(wide), .rd_val(rd_val), .drv_bus(dev_bus),
      .drv_bus_en(dev_bus_en), .drv_sio(dev_sio), .drv_sio_en(dev_sio_en),
      .got_byte(got_byte), .got_sel(got_sel), .got_cnt(got_cnt));

   always #50 clk = ~clk;

   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   // Called just after a rising edge; returns just after one
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) begin
            fails++;
            wrap_up();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic xfer(input logic rd, input logic sel, input logic [7:0] d);
      int c0;
      c0 = got_cnt;
      apb(1'b1, dmh_pkg::ADDR_CMD, {22'h0, rd, sel, d}, r, e);
      chk(32'(e), 32'h0000_0000, "command refused");
      // A second order while busy must bounce, not queue
      apb(1'b1, dmh_pkg::ADDR_CMD, 32'h0000_00FF, r, e);
      chk(32'(e), 32'h0000_0001, "busy command taken");
      r = 32'h0000_0000;
      for (int i = 0; r[dmh_pkg::ST_DONE_BIT] !== 1'b1; i++) begin
         if (i > 200) begin
            fails++;
            wrap_up();
         end
         apb(1'b0, dmh_pkg::ADDR_STATUS, 32'h0000_0000, r, e);
      end
      chk(32'(got_cnt), 32'(c0 + 1), "transfer count");
      chk(32'(got_sel), 32'(sel), "select level");
      if (rd) begin
         apb(1'b0, dmh_pkg::ADDR_RDATA, 32'h0000_0000, r, e);
         chk(32'(r[7:0]), 32'(rd_val), "read byte");
      end else
         chk(32'(got_byte), 32'(d), "written byte");
   endtask

   // -----------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------
   initial begin
      clk       = 1'b0;
      resetn    = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0000_0000;
      style     = 2'd3;  // Reserved: reset edges on pins move nothing
      wide      = 1'b1;
      rd_val    = 8'h00;
      fails     = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      apb(1'b1, dmh_pkg::ADDR_CMD, 32'h0000_0041, r, e);
      chk(32'(e), 32'h0000_0001, "early command taken");
      apb(1'b0, dmh_pkg::ADDR_CTRL, 32'h0000_0000, r, e);
      chk(r, dmh_pkg::CTRL_RESET, "control reset value");
      apb(1'b0, 8'h10, 32'h0000_0000, r, e);
      chk(32'(e), 32'h0000_0001, "unmapped access");
      r = 32'h0000_0000;
      for (int i = 0; r[dmh_pkg::ST_READY_BIT] !== 1'b1; i++) begin
         if (i > 50) begin
            fails++;
            wrap_up();
         end
         apb(1'b0, dmh_pkg::ADDR_STATUS, 32'h0000_0000, r, e);
      end
      $display("power-up test done");
      // Serial ignores width, so both of its passes behave alike
      for (int s = 0; s < 3; s++) begin
         for (int w = 1; w >= 0; w--) begin
            style  <= 2'(s);
            wide   <= w[0];
            rd_val <= 8'h96 ^ 8'(s * 16 + w);
            apb(1'b1, dmh_pkg::ADDR_CTRL, {29'h0, w[0], 2'(s)}, r, e);
            xfer(1'b0, 1'b0, 8'hA5);
            xfer(1'b0, 1'b1, 8'h3C);
            xfer(1'b1, 1'b1, 8'h00);
            xfer(1'b1, 1'b0, 8'h00);
            $display("style %0d wide %0d test done", s, w);
         end
      end
      wrap_up();
   end
endmodule // tb_top
